// *** inc/qtl_cfg.svh ***
// register offsets, field positions, reset values and timing counts of the trigger block
// assumes a 32-bit word-per-register apb map and a 10 MHz sampling clock
`ifndef QTL_CFG_SVH
`define QTL_CFG_SVH
`define QTL_OFS_CTRL 8'h00
`define QTL_OFS_PATTERN 8'h04
`define QTL_OFS_LIMIT_A 8'h08
`define QTL_OFS_LIMIT_B 8'h0c
`define QTL_OFS_HOLDOFF 8'h10
`define QTL_OFS_WAIT 8'h14
`define QTL_OFS_VIDEO 8'h18
`define QTL_OFS_VIDEO_CUSTOM 8'h1c
`define QTL_OFS_STATUS 8'h20
`define QTL_CTRL_MODE 2:0
`define QTL_CTRL_SRC 4:3
`define QTL_CTRL_QUAL 6:5
`define QTL_CTRL_QUAL_IS_PAT 7
`define QTL_CTRL_RISING 8
`define QTL_CTRL_PAT_PRESENT 9
`define QTL_CTRL_GLITCH_UPPER 10
`define QTL_CTRL_IV_UP_EN 11
`define QTL_CTRL_IV_LO_EN 12
`define QTL_CTRL_PAT_EXIT 13
`define QTL_CTRL_QUAL_BELOW 14
`define QTL_CTRL_WAIT 16:15
`define QTL_CTRL_HOLD 18:17
`define QTL_VID_FIELDS 3:0
`define QTL_VID_STD 5:4
`define QTL_VID_LINE 16:6
`define QTL_CUS_LINES 10:0
`define QTL_RST_CTRL 32'h0000_0000
`define QTL_RST_VIDEO 32'h0000_0048
`define QTL_RST_CUSTOM 32'h0000_0000
`define QTL_RST_LIMIT 32'h0000_0001
`define QTL_MAX_FIELDS 4'h8
`define QTL_LINES_625 11'h271
`define QTL_LINES_525 11'h20d
`define QTL_TIME_UNIT_NS 34'h0_0000_000a
`define QTL_CLK_PERIOD_NS 34'h0_0000_0064
`endif

// *** inc/qtl_chan_if.sv ***
// carries the cleaned comparator levels and their edges to the trigger logic
// assumes one sampling clock shared by both ends
`timescale 1ns/100ps
interface qtl_chan_if;
  logic [3:0] lvl;
  logic [3:0] rise;
  logic [3:0] fall;
  modport src (output lvl, output rise, output fall);
  modport dst (input lvl, input rise, input fall);
endinterface : qtl_chan_if

// *** inc/qtl_pkg.sv ***
// types shared by the trigger logic and its input synchroniser
// assumes qtl_cfg.svh for every number
`include "qtl_cfg.svh"
package qtl_pkg;
  typedef enum logic [2:0] {MODE_GLITCH, MODE_INTERVAL, MODE_PATTERN, MODE_STATEQ,
    MODE_EDGEQ, MODE_DROPOUT, MODE_VIDEO, MODE_IDLE} qtl_mode_t;
  typedef enum logic [1:0] {WAIT_WITHIN, WAIT_AFTER, WAIT_EVENTS, WAIT_NONE} qtl_wait_t;
  typedef enum logic [1:0] {HOLD_OFF, HOLD_TIME, HOLD_EVENTS, HOLD_RSVD} qtl_hold_t;
  typedef struct packed {
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic [31:0] ctrl;
    logic [7:0] pattern;
    logic [31:0] limA;
    logic [31:0] limB;
    logic [31:0] hold;
    logic [31:0] waitVal;
    logic [31:0] video;
    logic [31:0] custom;
    logic [31:0] cnt;
    logic [31:0] evCnt;
    logic [31:0] holdCnt;
    logic holdAct;
    logic haveEdge;
    logic armed;
    logic prevMatch;
    logic prevQual;
    logic [10:0] line;
    logic trig;
    logic [15:0] trigCount;
  } qtl_state_t;
  typedef struct packed {
    logic [3:0] ff1;
    logic [3:0] ff2;
    logic [3:0] ff3;
    logic [3:0] lvl;
    logic [3:0] rise;
    logic [3:0] fall;
  } qtl_sync_state_t;
endpackage : qtl_pkg

// *** logic/qtl_chan_sync.sv ***
// three-stage synchroniser for the comparator outputs, with edge pulses
// assumes asynchronous comparator inputs; a change counts once stages two and three agree
`timescale 1ns/100ps
module qtl_chan_sync
  import qtl_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [3:0] compIn,
  qtl_chan_if.src chan
);
  qtl_sync_state_t s_reg;
  qtl_sync_state_t s_next;
  logic [3:0] agree;

  always_comb
  begin
    s_next = s_reg;
    agree = ~(s_reg.ff2 ^ s_reg.ff3);
    s_next.ff1 = compIn;
    s_next.ff2 = s_reg.ff1;
    s_next.ff3 = s_reg.ff2;
    s_next.lvl = (s_reg.ff3 & agree) | (s_reg.lvl & ~agree);
    s_next.rise = s_next.lvl & ~s_reg.lvl;
    s_next.fall = ~s_next.lvl & s_reg.lvl;
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign chan.lvl = s_reg.lvl;
  assign chan.rise = s_reg.rise;
  assign chan.fall = s_reg.fall;
endmodule : qtl_chan_sync

// *** logic/qtl_trigger.sv ***
// qualified trigger decision logic with an apb register file
// assumes four comparator outputs from the analog front end and an apb master on sys_clk
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/100ps
module qtl_trigger
  import qtl_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] compIn,
  output logic trigOut
);
  qtl_state_t s_reg;
  qtl_state_t s_next;
  qtl_chan_if chan ();

  // times are programmed in 10 ns units; least times round up to whole clocks
  function automatic logic [31:0] toCycles(input logic [31:0] units);
    logic [35:0] ns;
    logic [35:0] cyc;
    begin
      // 36 bits hold the full 42.9 s range in ns without wrapping
      ns = 36'(units) * 36'(`QTL_TIME_UNIT_NS);
      cyc = (ns + 36'(`QTL_CLK_PERIOD_NS) - 36'h1) / 36'(`QTL_CLK_PERIOD_NS);
      if (cyc == 36'h0)
        cyc = 36'h1;
      toCycles = cyc[31:0];
    end
  endfunction : toCycles

  function automatic logic [31:0] satInc(input logic [31:0] v);
    begin
      satInc = (v == 32'hffff_ffff) ? v : v + 32'h1;
    end
  endfunction : satInc

  qtl_chan_sync u_sync (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .compIn(compIn),
    .chan(chan)
  );

  qtl_mode_t mode;
  qtl_wait_t waitKind;
  qtl_hold_t holdKind;
  logic [1:0] srcSel;
  logic [1:0] qualSel;
  logic srcEvt;
  logic qualEvt;
  logic patMatch;
  logic patCond;
  logic qualValid;
  logic [31:0] limACyc;
  logic [31:0] limBCyc;
  logic [31:0] holdCyc;
  logic [31:0] waitCyc;
  logic [10:0] frameLines;
  logic apbAccess;
  logic apbDone;
  logic addrOk;

  assign mode = qtl_mode_t'(s_reg.ctrl[`QTL_CTRL_MODE]);
  assign waitKind = qtl_wait_t'(s_reg.ctrl[`QTL_CTRL_WAIT]);
  assign holdKind = qtl_hold_t'(s_reg.ctrl[`QTL_CTRL_HOLD]);
  assign srcSel = s_reg.ctrl[`QTL_CTRL_SRC];
  assign qualSel = s_reg.ctrl[`QTL_CTRL_QUAL];
  assign limACyc = toCycles(s_reg.limA);
  assign limBCyc = toCycles(s_reg.limB);
  assign holdCyc = toCycles(s_reg.hold);
  assign waitCyc = toCycles(s_reg.waitVal);

  // source events use the configured slope
  assign srcEvt = s_reg.ctrl[`QTL_CTRL_RISING] ? chan.rise[srcSel] : chan.fall[srcSel];

  // bit 2k+1 = channel cares, bit 2k = wanted level; don't-care lanes always match
  always_comb
  begin
    patMatch = 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      if (s_reg.pattern[2 * k + 1] && (chan.lvl[k] != s_reg.pattern[2 * k]))
        patMatch = 1'b0;
    end
  end

  assign patCond = s_reg.ctrl[`QTL_CTRL_PAT_PRESENT] ? patMatch : ~patMatch;
  assign qualValid = s_reg.ctrl[`QTL_CTRL_QUAL_IS_PAT] ? patCond :
    (chan.lvl[qualSel] ^ s_reg.ctrl[`QTL_CTRL_QUAL_BELOW]);
  assign qualEvt = qualValid & ~s_reg.prevQual;

  always_comb
  begin
    case (s_reg.video[`QTL_VID_STD])
      2'h0: frameLines = `QTL_LINES_625;
      2'h1: frameLines = `QTL_LINES_525;
      default: frameLines = s_reg.custom[`QTL_CUS_LINES];
    endcase
  end

  assign apbAccess = psel & penable;
  assign apbDone = apbAccess & s_reg.ready;
  assign addrOk = (paddr[1:0] == 2'h0) && (paddr <= `QTL_OFS_STATUS);

  logic hit;
  logic cfgWrite;
  logic upOk;
  logic loOk;
  logic ivOk;

  always_comb
  begin
    s_next = s_reg;
    s_next.trig = 1'b0;
    hit = 1'b0;
    upOk = 1'b0;
    loOk = 1'b0;
    ivOk = 1'b0;
    cfgWrite = apbDone && pwrite && addrOk && (paddr != `QTL_OFS_STATUS);

    // apb: ready rises one cycle into the access phase, transfer ends on the next edge
    s_next.ready = apbAccess & ~s_reg.ready;
    if (apbAccess && !s_reg.ready)
    begin
      s_next.err = ~addrOk;
      s_next.rdata = 32'h0;
      if (!pwrite && addrOk)
      begin
        case (paddr)
          `QTL_OFS_CTRL: s_next.rdata = s_reg.ctrl;
          `QTL_OFS_PATTERN: s_next.rdata = {24'h0, s_reg.pattern};
          `QTL_OFS_LIMIT_A: s_next.rdata = s_reg.limA;
          `QTL_OFS_LIMIT_B: s_next.rdata = s_reg.limB;
          `QTL_OFS_HOLDOFF: s_next.rdata = s_reg.hold;
          `QTL_OFS_WAIT: s_next.rdata = s_reg.waitVal;
          `QTL_OFS_VIDEO: s_next.rdata = s_reg.video;
          `QTL_OFS_VIDEO_CUSTOM: s_next.rdata = s_reg.custom;
          default: s_next.rdata = {s_reg.trigCount, 1'b0, s_reg.line, s_reg.armed,
            s_reg.haveEdge, s_reg.holdAct, chan.lvl[0]};
        endcase
      end
    end
    else
    begin
      s_next.err = 1'b0;
    end

    if (cfgWrite)
    begin
      case (paddr)
        `QTL_OFS_CTRL: s_next.ctrl = pwdata;
        `QTL_OFS_PATTERN: s_next.pattern = pwdata[7:0];
        `QTL_OFS_LIMIT_A: s_next.limA = pwdata;
        `QTL_OFS_LIMIT_B: s_next.limB = pwdata;
        `QTL_OFS_HOLDOFF: s_next.hold = pwdata;
        `QTL_OFS_WAIT: s_next.waitVal = pwdata;
        `QTL_OFS_VIDEO:
        begin
          s_next.video = pwdata;
          if (pwdata[`QTL_VID_FIELDS] > `QTL_MAX_FIELDS)
            s_next.video[`QTL_VID_FIELDS] = `QTL_MAX_FIELDS;
          else if (pwdata[`QTL_VID_FIELDS] == 4'h0)
            s_next.video[`QTL_VID_FIELDS] = 4'h1;
        end
        default: s_next.custom = pwdata;
      endcase
      // a stale count measured against the old setting would fire falsely
      s_next.cnt = 32'h0;
      s_next.evCnt = 32'h0;
      s_next.holdCnt = 32'h0;
      s_next.holdAct = 1'b0;
      s_next.haveEdge = 1'b0;
      s_next.armed = 1'b0;
      s_next.line = 11'h0;
      s_next.prevMatch = patMatch;
      s_next.prevQual = qualValid;
    end
    else
    begin
      s_next.prevMatch = patMatch;
      s_next.prevQual = qualValid;
      s_next.cnt = satInc(s_reg.cnt);
      case (mode)
        MODE_GLITCH:
        begin
          if (patCond)
          begin
            s_next.cnt = s_reg.prevMatch == patMatch ? satInc(s_reg.cnt) : 32'h1;
          end
          else if (s_reg.haveEdge)
          begin
            // width is judged when the condition ends
            if (s_reg.ctrl[`QTL_CTRL_GLITCH_UPPER])
              hit = s_reg.cnt < limACyc;
            else
              hit = s_reg.cnt > limACyc;
          end
          s_next.haveEdge = patCond;
        end
        MODE_INTERVAL:
        begin
          if (srcEvt)
          begin
            upOk = s_reg.cnt < limACyc;
            loOk = s_reg.cnt > limBCyc;
            case ({s_reg.ctrl[`QTL_CTRL_IV_UP_EN], s_reg.ctrl[`QTL_CTRL_IV_LO_EN]})
              2'b10: ivOk = upOk;
              2'b01: ivOk = loOk;
              2'b11: ivOk = (limACyc > limBCyc) ? (upOk & loOk) : (upOk | loOk);
              default: ivOk = 1'b0;
            endcase
            hit = s_reg.haveEdge & ivOk;
            s_next.haveEdge = 1'b1;
            s_next.cnt = 32'h1;
          end
        end
        MODE_PATTERN:
        begin
          if (s_reg.ctrl[`QTL_CTRL_PAT_EXIT])
            hit = s_reg.prevMatch & ~patMatch;
          else
            hit = ~s_reg.prevMatch & patMatch;
        end
        MODE_STATEQ:
        begin
          if (!qualValid)
          begin
            s_next.cnt = 32'h0;
            s_next.evCnt = 32'h0;
          end
          else
          begin
            if (qualEvt)
              s_next.cnt = 32'h1;
            if (srcEvt)
            begin
              case (waitKind)
                WAIT_WITHIN: hit = s_reg.cnt < waitCyc;
                WAIT_AFTER: hit = s_reg.cnt >= waitCyc;
                WAIT_EVENTS:
                begin
                  hit = s_reg.evCnt >= s_reg.waitVal;
                  s_next.evCnt = satInc(s_reg.evCnt);
                end
                default: hit = 1'b1;
              endcase
            end
          end
        end
        MODE_EDGEQ:
        begin
          if (qualEvt)
          begin
            s_next.armed = 1'b1;
            s_next.cnt = 32'h1;
            s_next.evCnt = 32'h0;
          end
          else if (s_reg.armed && srcEvt)
          begin
            case (waitKind)
              WAIT_WITHIN: hit = s_reg.cnt < waitCyc;
              WAIT_AFTER: hit = s_reg.cnt >= waitCyc;
              WAIT_EVENTS:
              begin
                hit = s_reg.evCnt >= s_reg.waitVal;
                s_next.evCnt = satInc(s_reg.evCnt);
              end
              default: hit = 1'b1;
            endcase
            if (hit)
              s_next.armed = 1'b0;
          end
        end
        MODE_DROPOUT:
        begin
          if (srcEvt)
          begin
            s_next.cnt = 32'h1;
            s_next.armed = 1'b1;
          end
          else if (s_reg.armed && s_reg.cnt >= limACyc)
          begin
            // one trigger per silence; the next edge rearms
            hit = 1'b1;
            s_next.armed = 1'b0;
          end
        end
        MODE_VIDEO:
        begin
          // line pulses are counted on the source; field sync is decoded upstream
          if (srcEvt)
          begin
            s_next.line = (s_reg.line + 11'h1 >= frameLines) ? 11'h0 : s_reg.line + 11'h1;
            hit = s_reg.line == s_reg.video[`QTL_VID_LINE];
          end
        end
        default: hit = 1'b0;
      endcase

      if (s_reg.holdAct)
      begin
        hit = 1'b0;
        if (holdKind == HOLD_TIME)
          s_next.holdCnt = satInc(s_reg.holdCnt);
        else if (srcEvt)
          s_next.holdCnt = satInc(s_reg.holdCnt);
        if ((holdKind == HOLD_TIME && s_reg.holdCnt + 32'h1 >= holdCyc) ||
            (holdKind == HOLD_EVENTS && srcEvt && s_reg.holdCnt + 32'h1 >= s_reg.hold))
          s_next.holdAct = 1'b0;
      end
      if (hit)
      begin
        s_next.trig = 1'b1;
        s_next.trigCount = s_reg.trigCount + 16'h1;
        s_next.holdCnt = 32'h0;
        s_next.holdAct = (holdKind == HOLD_TIME) || (holdKind == HOLD_EVENTS);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_reg <= '0;
      s_reg.ctrl <= `QTL_RST_CTRL;
      s_reg.limA <= `QTL_RST_LIMIT;
      s_reg.limB <= `QTL_RST_LIMIT;
      s_reg.hold <= `QTL_RST_LIMIT;
      s_reg.waitVal <= `QTL_RST_LIMIT;
      s_reg.video <= `QTL_RST_VIDEO;
      s_reg.custom <= `QTL_RST_CUSTOM;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign prdata = s_reg.rdata;
  assign pready = s_reg.ready;
  assign pslverr = s_reg.err;
  assign trigOut = s_reg.trig;
endmodule : qtl_trigger

// *** tb/qtl_comp_model.sv ***
// comparator outputs of the four analog channels
// assumes the bench calls pulses; levels change just after a rising edge
`timescale 1ns/100ps
module qtl_comp_model
(
  input wire logic sys_clk,
  output logic [3:0] compIn
);
  initial compIn = 4'h0;

  // a comparator always drives a level, so there is no released state
  task automatic pulses(input logic [3:0] on, input int hi, input int lo, input int reps);
    repeat (reps)
    begin
      @(posedge sys_clk);
      compIn <= on;
      repeat (hi) @(posedge sys_clk);
      compIn <= 4'h0;
      repeat (lo - 1) @(posedge sys_clk);
    end
  endtask : pulses
endmodule : qtl_comp_model

// *** tb/qtl_trigger_sva.sv ***
// concurrent checks on the apb port and trigger output of the trigger block
// assumes it is bound to qtl_trigger and sees only that module's ports
`timescale 1ns/100ps
module qtl_trigger_sva
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [3:0] compIn,
  input wire logic trigOut
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);
  logic mapped;
  assign mapped = (paddr <= 8'h20) && (paddr[1:0] == 2'b00);

  setup_answer_a: assert property (psel && !penable |-> ##2 pready)
    else $error("no answer two cycles after setup");
  access_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("access phase not answered next cycle");
  ready_in_access_a: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  bad_addr_a: assert property (pready && !mapped |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  good_addr_a: assert property (pready && mapped |-> !pslverr)
    else $error("mapped access refused");
  reset_quiet_a: assert property ($rose(arst_n) |-> !trigOut && !pready && !pslverr)
    else $error("outputs active right after reset");

  cover property (pready && pwrite && !pslverr);
  cover property (pready && pslverr);
  cover property (trigOut);
endmodule : qtl_trigger_sva

// *** tb/qualified_trigger_logic_tb_top.sv ***
// self-checking bench for the qualified trigger block
// assumes qtl_trigger, qtl_comp_model and qtl_trigger_sva are compiled first
`timescale 1ns/100ps
module qualified_trigger_logic_tb_top;
  logic sys_clk;
  logic arst_n;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] compIn;
  logic trigOut;
  int mismatches;
  int checksDone;

  qtl_trigger i_qtl_trigger (.sys_clk(sys_clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .compIn(compIn), .trigOut(trigOut));
  qtl_comp_model i_qtl_comp_model (.sys_clk(sys_clk), .compIn(compIn));

  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic stop_test;
    if (mismatches == 0 && checksDone > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test

  task automatic chkReg(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chkReg

  task automatic chkBit(input logic got, input logic exp);
    chkReg({31'h0, got}, {31'h0, exp});
  endtask : chkBit

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] rd, output logic er);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      mismatches++;
      stop_test();
    end
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic er;
    apb(1'b1, a, d, rd, er);
    chkBit(er, 1'b0);
  endtask : wr

  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input logic expErr);
    logic [31:0] rd;
    logic er;
    apb(1'b0, a, 32'h0000_0000, rd, er);
    chkReg(rd, exp);
    chkBit(er, expErr);
  endtask : rdChk

  task automatic regTest;
    logic [31:0] rd;
    logic er;
    rdChk(8'h00, 32'h0000_0000, 1'b0);
    rdChk(8'h08, 32'h0000_0001, 1'b0);
    rdChk(8'h18, 32'h0000_0048, 1'b0);
    apb(1'b1, 8'h24, 32'h0000_00ff, rd, er);
    chkBit(er, 1'b1);
    rdChk(8'h02, 32'h0000_0000, 1'b1);
    wr(8'h20, 32'h0000_00ff);
    wr(8'h04, 32'h0000_0003);
    rdChk(8'h04, 32'h0000_0003, 1'b0);
  endtask : regTest

  // idle first so pin changes during the rewrite cannot leave stale state behind
  task automatic runCase(input logic [31:0] c, input logic [31:0] la, input logic [31:0] lb,
    input logic [3:0] on, input int hi, input int lo, input int reps, input int win,
    input int expN);
    int n;
    wr(8'h00, 32'h0000_0007);
    wr(8'h08, la);
    wr(8'h0c, lb);
    wr(8'h00, c);
    repeat (6) @(posedge sys_clk);
    n = 0;
    fork
      i_qtl_comp_model.pulses(on, hi, lo, reps);
      repeat (win)
      begin
        @(posedge sys_clk);
        if (trigOut === 1'b1)
          n++;
      end
    join
    chkReg(32'(n), 32'(expN));
  endtask : runCase

  initial
  begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    mismatches = 0;
    checksDone = 0;
    repeat (16) @(posedge sys_clk);
    arst_n <= 1'b1;
    regTest();
    runCase(32'h0000_0600, 32'd50, 32'd1, 4'h1, 2, 1, 1, 20, 1);
    runCase(32'h0000_0600, 32'd50, 32'd1, 4'h1, 10, 1, 1, 20, 0);
    runCase(32'h0000_0200, 32'd50, 32'd1, 4'h1, 10, 1, 1, 20, 1);
    runCase(32'h0000_0200, 32'd50, 32'd1, 4'h1, 2, 1, 1, 20, 0);
    // one-cycle pin pulses are filtered by the synchroniser, so levels last two cycles or more
    runCase(32'h0000_0901, 32'd50, 32'd50, 4'h1, 2, 2, 3, 20, 2);
    runCase(32'h0000_0901, 32'd50, 32'd50, 4'h1, 2, 8, 3, 40, 0);
    runCase(32'h0000_0801, 32'd50, 32'd50, 4'h1, 2, 2, 3, 20, 2);
    runCase(32'h0000_1101, 32'd50, 32'd50, 4'h1, 2, 8, 3, 40, 2);
    runCase(32'h0000_1101, 32'd50, 32'd50, 4'h1, 2, 2, 3, 20, 0);
    runCase(32'h0000_1901, 32'd50, 32'd30, 4'h1, 2, 2, 3, 25, 2);
    runCase(32'h0000_1901, 32'd50, 32'd30, 4'h1, 2, 8, 3, 40, 0);
    runCase(32'h0000_1901, 32'd30, 32'd80, 4'h1, 2, 8, 3, 40, 2);
    runCase(32'h0000_1901, 32'd30, 32'd80, 4'h1, 2, 3, 3, 25, 0);
    runCase(32'h0000_0002, 32'd1, 32'd1, 4'h1, 15, 1, 1, 12, 1);
    runCase(32'h0000_2002, 32'd1, 32'd1, 4'h1, 15, 1, 1, 12, 0);
    runCase(32'h0000_2002, 32'd1, 32'd1, 4'h1, 3, 10, 1, 12, 1);
    runCase(32'h0000_0002, 32'd1, 32'd1, 4'h2, 3, 3, 3, 25, 0);
    runCase(32'h0000_0002, 32'd1, 32'd1, 4'h1, 3, 3, 3, 30, 3);
    wr(8'h10, 32'd3000);
    runCase(32'h0002_0002, 32'd1, 32'd1, 4'h1, 3, 3, 3, 30, 1);
    runCase(32'h0002_0002, 32'd1, 32'd1, 4'h1, 3, 3, 1, 12, 1);
    runCase(32'h0001_8123, 32'd1, 32'd1, 4'h3, 3, 3, 3, 30, 3);
    runCase(32'h0001_8123, 32'd1, 32'd1, 4'h1, 3, 3, 3, 30, 0);
    runCase(32'h0000_c123, 32'd1, 32'd1, 4'h1, 3, 3, 3, 30, 3);
    runCase(32'h0000_4123, 32'd1, 32'd1, 4'h1, 3, 3, 3, 30, 0);
    runCase(32'h0000_8024, 32'd1, 32'd1, 4'h3, 3, 3, 3, 30, 3);
    runCase(32'h0000_0024, 32'd1, 32'd1, 4'h3, 3, 3, 3, 30, 0);
    runCase(32'h0000_8024, 32'd1, 32'd1, 4'h1, 3, 3, 3, 30, 0);
    runCase(32'h0000_0106, 32'd1, 32'd1, 4'h1, 3, 3, 3, 30, 1);
    wr(8'h10, 32'd2);
    runCase(32'h0004_0002, 32'd1, 32'd1, 4'h1, 3, 3, 4, 35, 2);
    runCase(32'h0000_0105, 32'd80, 32'd1, 4'h1, 30, 1, 1, 9, 0);
    runCase(32'h0000_0105, 32'd80, 32'd1, 4'h1, 30, 1, 1, 25, 1);
    runCase(32'h0000_0005, 32'd80, 32'd1, 4'h1, 30, 1, 1, 25, 0);
    stop_test();
  end

  initial
  begin
    repeat (60000) @(posedge sys_clk);
    mismatches++;
    stop_test();
  end
endmodule : qualified_trigger_logic_tb_top

bind qtl_trigger qtl_trigger_sva i_qtl_trigger_sva (.sys_clk(sys_clk), .arst_n(arst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .compIn(compIn), .trigOut(trigOut));
